// ### hdl/dual_uart_decode_pkg.sv
// Constants shared by the dual UART port decode and interrupt routing logic.
package dual_uart_decode_pkg;

    // ------------------------------------------------------------------
    // Fixed I/O address and setup register indices
    // ------------------------------------------------------------------
    localparam logic [15:0] FIXED_REG_ADDR      = 16'h02F7;
    localparam logic [2:0]  CFG_LOW_INDEX       = 3'h2;
    localparam logic [2:0]  CFG_HIGH_INDEX      = 3'h3;

    // ------------------------------------------------------------------
    // Field positions in port_select_config_low
    // ------------------------------------------------------------------
    localparam int          CARD_ENABLE_BIT     = 0;
    localparam int          CH1_HIGH_GROUP_BIT  = 6;
    localparam int          CH1_PORT1_BIT       = 5;
    localparam int          CH1_ADDR3_BIT       = 4;
    localparam int          CH2_HIGH_GROUP_BIT  = 3;
    localparam int          CH2_PORT1_BIT       = 2;
    localparam int          CH2_ADDR3_BIT       = 1;

    // ------------------------------------------------------------------
    // Field positions in port_select_config_high
    // ------------------------------------------------------------------
    localparam int          CH1_UPPER_LSB       = 3;
    localparam int          CH2_UPPER_LSB       = 0;
    localparam int          UPPER_WIDTH         = 3;

    // ------------------------------------------------------------------
    // Status bit positions and reset values
    // ------------------------------------------------------------------
    localparam int          STATUS_CH1_BIT      = 0;
    localparam int          STATUS_CH2_BIT      = 1;
    localparam int          STATUS_TC_BIT       = 2;
    localparam logic [7:0]  CFG_RESET           = 8'h00;
    localparam logic [7:0]  DMA_ENABLE_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // Hard-wired comparator levels and cycle length
    // ------------------------------------------------------------------
    localparam logic        ZERO_GROUP_EXPECT   = 1'b1;
    localparam logic        ONE_GROUP_EXPECT    = 1'b0;
    localparam logic        UPPER_MATCH_EXPECT  = 1'b0;
    localparam int          UART_WAIT_STATES    = 0;
    localparam int          CHANNEL_COUNT       = 2;

endpackage : dual_uart_decode_pkg

// ### hdl/chan_match_if.sv
// Interface joining the top decode logic to one channel comparator.
`timescale 1ns/10ps
interface chan_match_if;
    logic [15:0] address;
    logic        ioCycle;
    logic        cardEnable;
    logic        highGroupCfg;
    logic        port1Cfg;
    logic        addr3Cfg;
    logic [2:0]  upperCfg;
    logic        selectN;

    modport top (output address, output ioCycle, output cardEnable, output highGroupCfg,
                 output port1Cfg, output addr3Cfg, output upperCfg, input selectN);
    modport cmp (input address, input ioCycle, input cardEnable, input highGroupCfg,
                 input port1Cfg, input addr3Cfg, input upperCfg, output selectN);
endinterface : chan_match_if

// ### hdl/channel_comparator.sv
// Unlatched address comparator for one UART channel.
`timescale 1ns/10ps
module channel_comparator
    import dual_uart_decode_pkg::*;
(
    chan_match_if.cmp m
);
    logic zeroGroup;
    logic oneGroup;
    logic highGroup;
    logic upperMatchN;
    logic allMatch;

    always_comb begin
        zeroGroup   = ~(m.address[15] | m.address[11] | m.address[10]);
        oneGroup    = ~(m.address[9] & m.address[5]);
        highGroup   = ~(m.address[7] & m.address[6] & m.address[4]);
        upperMatchN = (m.address[14:12] == m.upperCfg) ? 1'b0 : 1'b1;             // [R8]
        allMatch    = (zeroGroup == ZERO_GROUP_EXPECT)                            // [R3]
                    & (oneGroup == ONE_GROUP_EXPECT)                              // [R4]
                    & (highGroup == m.highGroupCfg)                               // [R5]
                    & (m.address[8] == m.port1Cfg)                                // [R6]
                    & (m.address[3] == m.addr3Cfg)                                // [R7]
                    & (upperMatchN == UPPER_MATCH_EXPECT)                         // [R8]
                    & m.cardEnable                                                // [R9]
                    & m.ioCycle;                                                  // [R10]
        m.selectN   = ~allMatch;                                                  // [R11]
    end
endmodule : channel_comparator

// ### hdl/interrupt_router.sv
// Routes the two serial interrupts and the terminal-count interrupt to two lines.
`timescale 1ns/10ps
module interrupt_router
(
    input  wire logic uartChOneIrq,
    input  wire logic uartChTwoIrq,
    input  wire logic terminalCount,
    input  wire logic chOnePort1,
    input  wire logic chTwoPort1,
    input  wire logic cardEnable,
    output logic      lineThreeWant,
    output logic      lineFourWant
);
    always_comb begin
        lineThreeWant = cardEnable & (terminalCount                               // [R17]
                      | (uartChOneIrq & ~chOnePort1)
                      | (uartChTwoIrq & ~chTwoPort1));
        lineFourWant  = cardEnable & ((uartChOneIrq & chOnePort1)                 // [R17]
                      | (uartChTwoIrq & chTwoPort1));
    end
endmodule : interrupt_router

// ### hdl/dual_uart_port_decode_irq.sv
// Top of the dual UART port decode, register and interrupt routing logic.
//
// Overview of operation
// [R1] Decode upper 13 address bits; pass A2-A0.
// [R2] Each channel placeable at eight standard ports.
// [R3] NOR of A15, A11, A10 must be one.
// [R4] NAND of A9, A5 must be zero.
// [R5] NAND of A7, A6, A4 equals config bit.
// [R6] A8 equals per-channel port-one config bit.
// [R7] A3 equals per-channel config bit.
// [R8] A14-A12 compared with upper config fields.
// [R9] Card enable required before any decode.
// [R10] Only I/O cycles produce channel selects.
// [R11] Channel select low on full match only.
// [R12] Fixed 2F7h: write DMA enable, read status.
// [R13] Latch register bits and selects on command.
// [R14] Chip select is AND; channel two picks.
// [R15] No wait states on UART accesses.
// [R16] Interrupt lines active low, open drain.
// [R17] Route serial and terminal-count interrupts by port; terminal count always goes to line three; the code routes it there only while card enable is set.
// [R18] Channel reset clears the whole adapter state.
// [R19] Reset clears every configuration bit.
`timescale 1ns/10ps
module dual_uart_port_decode_irq
    import dual_uart_decode_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        channelReset,
    input  wire logic [15:0] address,
    input  wire logic        memNotIo,
    input  wire logic        cmdN,
    input  wire logic        ioReadN,
    input  wire logic        ioWriteN,
    input  wire logic        setupN,
    input  wire logic [7:0]  dataIn,
    output logic [7:0]       dataOut,
    output logic             dataOeN,
    output logic             dataBufferDirection,
    output logic             dataBufferEnableN,
    output logic             cardSelect,
    output logic             cardReady,
    output logic [2:0]       uartRegSelect,
    output logic             channelOneSelectN,
    output logic             channelTwoSelectN,
    output logic             uartChipSelectN,
    output logic             uartChannelPick,
    input  wire logic        uartChOneIrq,
    input  wire logic        uartChTwoIrq,
    input  wire logic        terminalCount,
    input  wire logic        irqThreeIn,
    output logic             irqThreeOut,
    output logic             irqThreeOeN,
    input  wire logic        irqFourIn,
    output logic             irqFourOut,
    output logic             irqFourOeN,
    output logic [7:0]       dmaRequestEnable,
    output logic [7:0]       portSelectConfigLow,
    output logic [7:0]       portSelectConfigHigh
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfgLow;
        logic [7:0] cfgHigh;
        logic [7:0] dmaEnable;
        logic       cmdPrev;
        logic [2:0] regSel;
        logic       chOneSelN;
        logic       chTwoSelN;
        logic       chipSelN;
        logic       channelPick;
        logic       cardSel;
        logic       ready;
        logic [7:0] readData;
        logic       dataDriveN;
        logic       data_buffer_direction;
        logic       bufEnN;
        logic       irqThreeDriveN;
        logic       irqFourDriveN;
    } state_s;

    localparam state_s STATE_RESET = '{
        cfgLow:         CFG_RESET,
        cfgHigh:        CFG_RESET,
        dmaEnable:      DMA_ENABLE_RESET,
        cmdPrev:        1'b1,
        regSel:         3'h0,
        chOneSelN:      1'b1,
        chTwoSelN:      1'b1,
        chipSelN:       1'b1,
        channelPick:    1'b1,
        cardSel:        1'b0,
        ready:          1'b1,
        readData:       8'h00,
        dataDriveN:     1'b1,
        data_buffer_direction:         1'b0,
        bufEnN:         1'b1,
        irqThreeDriveN: 1'b1,
        irqFourDriveN:  1'b1
    };

    state_s state_q;
    state_s state_d;

    // ------------------------------------------------------------------
    // Channel comparators
    // ------------------------------------------------------------------
    chan_match_if match[CHANNEL_COUNT] ();

    logic [CHANNEL_COUNT-1:0] liveSelectN;
    logic [CHANNEL_COUNT-1:0] highGroupBits;
    logic [CHANNEL_COUNT-1:0] port1Bits;
    logic [CHANNEL_COUNT-1:0] addr3Bits;
    logic [UPPER_WIDTH-1:0]   upperBits [CHANNEL_COUNT];

    // Channel one uses the upper config fields, channel two the lower.
    always_comb begin
        highGroupBits = {state_q.cfgLow[CH2_HIGH_GROUP_BIT], state_q.cfgLow[CH1_HIGH_GROUP_BIT]};
        port1Bits     = {state_q.cfgLow[CH2_PORT1_BIT], state_q.cfgLow[CH1_PORT1_BIT]};
        addr3Bits     = {state_q.cfgLow[CH2_ADDR3_BIT], state_q.cfgLow[CH1_ADDR3_BIT]};
        upperBits[0]  = state_q.cfgHigh[CH1_UPPER_LSB +: UPPER_WIDTH];
        upperBits[1]  = state_q.cfgHigh[CH2_UPPER_LSB +: UPPER_WIDTH];
    end

    // The comparison runs on the live address so that card select feedback is early.
    for (genvar ch = 0; ch < CHANNEL_COUNT; ch++) begin : g_channel
        assign match[ch].address      = address;                                  // [R1]
        assign match[ch].ioCycle      = ~memNotIo;                                // [R10]
        assign match[ch].cardEnable   = state_q.cfgLow[CARD_ENABLE_BIT];          // [R9]
        assign match[ch].highGroupCfg = highGroupBits[ch];                        // [R2]
        assign match[ch].port1Cfg     = port1Bits[ch];
        assign match[ch].addr3Cfg     = addr3Bits[ch];
        assign match[ch].upperCfg     = upperBits[ch];
        assign liveSelectN[ch]        = match[ch].selectN;

        channel_comparator u_comparator (
            .m (match[ch])
        );
    end

    // ------------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------------
    logic lineThreeWant;
    logic lineFourWant;

    interrupt_router u_router (
        .uartChOneIrq  (uartChOneIrq),
        .uartChTwoIrq  (uartChTwoIrq),
        .terminalCount (terminalCount),
        .chOnePort1    (state_q.cfgLow[CH1_PORT1_BIT]),
        .chTwoPort1    (state_q.cfgLow[CH2_PORT1_BIT]),
        .cardEnable    (state_q.cfgLow[CARD_ENABLE_BIT]),
        .lineThreeWant (lineThreeWant),
        .lineFourWant  (lineFourWant)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic       cmdStart;
    logic       cmdActive;
    logic       fixedHit;
    logic       setupMode;
    logic       uartHit;
    logic [7:0] statusByte;

    always_comb begin
        state_d    = state_q;
        cmdActive  = ~cmdN;
        cmdStart   = cmdActive & state_q.cmdPrev;
        setupMode  = ~setupN;
        fixedHit   = ~memNotIo & (address == FIXED_REG_ADDR)                     // [R12]
                   & state_q.cfgLow[CARD_ENABLE_BIT] & ~setupMode;
        uartHit    = ~setupMode & (liveSelectN != {CHANNEL_COUNT{1'b1}});
        statusByte = 8'h00;
        statusByte[STATUS_CH1_BIT] = uartChOneIrq;
        statusByte[STATUS_CH2_BIT] = uartChTwoIrq;
        statusByte[STATUS_TC_BIT]  = terminalCount;

        state_d.cmdPrev = cmdN;

        // Select feedback uses the unlatched decode.
        state_d.cardSel = uartHit | fixedHit;
        // Every access fits the default cycle, so ready is never pulled low.
        state_d.ready   = (UART_WAIT_STATES == 0);                                // [R15]

        // Register bits and selects are captured once per command and then held.
        if (cmdStart) begin
            state_d.regSel    = address[2:0];                                     // [R13]
            state_d.chOneSelN = setupMode | liveSelectN[0];                       // [R13]
            state_d.chTwoSelN = setupMode | liveSelectN[1];
        end else if (!cmdActive) begin
            state_d.chOneSelN = 1'b1;
            state_d.chTwoSelN = 1'b1;
        end
        state_d.chipSelN    = state_d.chOneSelN & state_d.chTwoSelN;              // [R14]
        state_d.channelPick = state_d.chTwoSelN;                                  // [R14]

        // Writes are taken once, at the start of the command.
        if (cmdStart && !ioWriteN) begin
            if (setupMode && address[2:0] == CFG_LOW_INDEX) begin
                state_d.cfgLow = dataIn;
            end else if (setupMode && address[2:0] == CFG_HIGH_INDEX) begin
                state_d.cfgHigh = dataIn;
            end else if (fixedHit) begin
                state_d.dmaEnable = dataIn;                                       // [R12]
            end
        end

        // Read data for the adapter's own registers; the UART drives its own reads.
        state_d.dataDriveN = 1'b1;
        state_d.readData   = 8'h00;
        if (cmdActive && !ioReadN) begin
            if (setupMode && address[2:0] == CFG_LOW_INDEX) begin
                state_d.readData   = state_q.cfgLow;
                state_d.dataDriveN = 1'b0;
            end else if (setupMode && address[2:0] == CFG_HIGH_INDEX) begin
                state_d.readData   = state_q.cfgHigh;
                state_d.dataDriveN = 1'b0;
            end else if (fixedHit) begin
                state_d.readData   = statusByte;                                  // [R12]
                state_d.dataDriveN = 1'b0;
            end
        end

        // The isolation buffer opens for card accesses and faces the host on reads.
        state_d.bufEnN = ~(cmdActive & (uartHit | fixedHit | setupMode));
        state_d.data_buffer_direction = ~ioReadN;

        // Lines are only pulled low; release lets other cards share them.
        state_d.irqThreeDriveN = ~lineThreeWant;                                  // [R16]
        state_d.irqFourDriveN  = ~lineFourWant;                                   // [R16]
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b || channelReset) begin
            state_q <= STATE_RESET;                                               // [R18] [R19]
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign dataOut              = state_q.readData;
    assign dataOeN              = state_q.dataDriveN;
    assign dataBufferDirection  = state_q.data_buffer_direction;
    assign dataBufferEnableN    = state_q.bufEnN;
    assign cardSelect           = state_q.cardSel;
    assign cardReady            = state_q.ready;
    assign uartRegSelect        = state_q.regSel;                                 // [R1]
    assign channelOneSelectN    = state_q.chOneSelN;
    assign channelTwoSelectN    = state_q.chTwoSelN;
    assign uartChipSelectN      = state_q.chipSelN;
    assign uartChannelPick      = state_q.channelPick;
    assign irqThreeOut          = 1'b0;
    assign irqThreeOeN          = state_q.irqThreeDriveN;
    assign irqFourOut           = 1'b0;
    assign irqFourOeN           = state_q.irqFourDriveN;
    assign dmaRequestEnable     = state_q.dmaEnable;
    assign portSelectConfigLow  = state_q.cfgLow;
    assign portSelectConfigHigh = state_q.cfgHigh;

endmodule : dual_uart_port_decode_irq

// ### verification/dual_uart_port_decode_irq_props.sv
// Port-level assertions for the dual UART decode block.
`timescale 1ns/10ps
module dual_uart_port_decode_irq_props
    import dual_uart_decode_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        channelReset,
    input wire logic [15:0] address,
    input wire logic        memNotIo,
    input wire logic        cmdN,
    input wire logic        setupN,
    input wire logic        cardReady,
    input wire logic [2:0]  uartRegSelect,
    input wire logic        channelOneSelectN,
    input wire logic        channelTwoSelectN,
    input wire logic        uartChipSelectN,
    input wire logic        uartChannelPick,
    input wire logic        uartChOneIrq,
    input wire logic        uartChTwoIrq,
    input wire logic        terminalCount,
    input wire logic        irqThreeOut,
    input wire logic        irqThreeOeN,
    input wire logic        irqFourOut,
    input wire logic        irqFourOeN,
    input wire logic [7:0]  portSelectConfigLow,
    input wire logic [7:0]  portSelectConfigHigh
);
    // ------------------------------------------------------------
    // Expected decode and routing
    // ------------------------------------------------------------
    logic [7:0] lo, hi;
    logic       base, matchOne, matchTwo, wantThree, wantFour;
    assign lo = portSelectConfigLow;
    assign hi = portSelectConfigHigh;
    assign base = setupN && !memNotIo && lo[0] && !(address[15] | address[11] | address[10]) && address[9] && address[5];
    assign matchOne = base && (~&{address[7], address[6], address[4]} == lo[6]) && address[8] == lo[5]
                      && address[3] == lo[4] && address[14:12] == hi[5:3];
    assign matchTwo = base && (~&{address[7], address[6], address[4]} == lo[3]) && address[8] == lo[2]
                      && address[3] == lo[1] && address[14:12] == hi[2:0];
    assign wantThree = lo[0] && (terminalCount || uartChOneIrq && !lo[5] || uartChTwoIrq && !lo[2]);
    assign wantFour = lo[0] && (uartChOneIrq && lo[5] || uartChTwoIrq && lo[2]);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b || channelReset);

    sequence cmdStart;
        !cmdN && $past(cmdN);
    endsequence

    a_ch_one_decode: assert property (cmdStart |=> channelOneSelectN == !$past(matchOne))
        else $error("ch1 select wrong");
    a_ch_two_decode: assert property (cmdStart |=> channelTwoSelectN == !$past(matchTwo))
        else $error("ch2 select wrong");
    a_regsel_latch: assert property (cmdStart ##0 (matchOne || matchTwo) |=> uartRegSelect == $past(address[2:0]))
        else $error("regsel wrong");
    a_cycle_hold: assert property (!cmdN ##1 !cmdN |=> $stable({uartRegSelect, channelOneSelectN, channelTwoSelectN}))
        else $error("select moved");
    a_select_release: assert property (cmdN |=> channelOneSelectN && channelTwoSelectN)
        else $error("select not released");
    a_chip_and: assert property (uartChipSelectN == (channelOneSelectN && channelTwoSelectN))
        else $error("chip select wrong");
    a_pick_follow: assert property (uartChannelPick == channelTwoSelectN)
        else $error("pick wrong");
    a_no_wait: assert property (cardReady)
        else $error("ready low");
    a_irq_three: assert property (1'h1 |=> irqThreeOeN == !$past(wantThree))
        else $error("irq3 wrong");
    a_irq_four: assert property (1'h1 |=> irqFourOeN == !$past(wantFour))
        else $error("irq4 wrong");
    a_irq_low_drive: assert property (!irqThreeOut && !irqFourOut)
        else $error("irq driven high");
endmodule : dual_uart_port_decode_irq_props

bind dual_uart_port_decode_irq dual_uart_port_decode_irq_props props_u (.clock, .rst_b, .channelReset, .address,
    .memNotIo, .cmdN, .setupN, .cardReady, .uartRegSelect, .channelOneSelectN, .channelTwoSelectN, .uartChipSelectN,
    .uartChannelPick, .uartChOneIrq, .uartChTwoIrq, .terminalCount, .irqThreeOut, .irqThreeOeN, .irqFourOut,
    .irqFourOeN, .portSelectConfigLow, .portSelectConfigHigh);

// ### verification/uart_irq_side_model.sv
// Far-side model: interrupt sources and the two pulled-up shared lines.
`timescale 1ns/10ps
module uart_irq_side_model
(
    input  wire logic [2:0] want,
    input  wire logic       lineThreeOeN,
    input  wire logic       lineFourOeN,
    input  wire logic       lineThreeOut,
    input  wire logic       lineFourOut,
    output logic            chOneIrq,
    output logic            chTwoIrq,
    output logic            tcIrq,
    output logic            lineThree,
    output logic            lineFour
);
    assign {tcIrq, chTwoIrq, chOneIrq} = want;
    // Released lines read as the pull-up level.
    assign lineThree = lineThreeOeN ? 1'h1 : lineThreeOut;
    assign lineFour = lineFourOeN ? 1'h1 : lineFourOut;
endmodule : uart_irq_side_model

// ### verification/dual_uart_port_decode_irq_bench.sv
// Self-checking bench for the dual UART decode block.
`timescale 1ns/10ps
module dual_uart_port_decode_irq_bench
    import dual_uart_decode_pkg::*;
;
    localparam logic [15:0] PORTS [8] = '{16'h03F8, 16'h02F8, 16'h3220, 16'h3228,
                                         16'h4220, 16'h4228, 16'h5220, 16'h5228};
    localparam logic [15:0] FLIPS [5] = '{16'h8000, 16'h0020, 16'h0008, 16'h0100, 16'h1000};
    logic        clock, rst_b, channelReset, memNotIo, cmdN, ioReadN, ioWriteN, setupN, cardReady;
    logic [15:0] address, c1, c2;
    logic [7:0]  dataIn, dataOut, dmaRequestEnable, portSelectConfigLow, portSelectConfigHigh, rd, lo, hi, sel;
    logic        dataOeN, dataBufferDirection, dataBufferEnableN, cardSelect, uartChannelPick;
    logic        channelOneSelectN, channelTwoSelectN, uartChipSelectN, uartChOneIrq, uartChTwoIrq;
    logic        terminalCount, irqThreeIn, irqFourIn, irqThreeOut, irqFourOut, irqThreeOeN, irqFourOeN;
    logic [2:0]  uartRegSelect, rs, irqWant;
    int          fail_count, checks;

    dual_uart_port_decode_irq dut_u (.clock, .rst_b, .channelReset, .address, .memNotIo, .cmdN, .ioReadN, .ioWriteN,
        .setupN, .dataIn, .dataOut, .dataOeN, .dataBufferDirection, .dataBufferEnableN, .cardSelect, .cardReady,
        .uartRegSelect, .channelOneSelectN, .channelTwoSelectN, .uartChipSelectN, .uartChannelPick, .uartChOneIrq,
        .uartChTwoIrq, .terminalCount, .irqThreeIn, .irqThreeOut, .irqThreeOeN, .irqFourIn, .irqFourOut,
        .irqFourOeN, .dmaRequestEnable, .portSelectConfigLow, .portSelectConfigHigh);
    uart_irq_side_model side_u (.want(irqWant), .lineThreeOeN(irqThreeOeN), .lineFourOeN(irqFourOeN),
        .lineThreeOut(irqThreeOut), .lineFourOut(irqFourOut), .chOneIrq(uartChOneIrq), .chTwoIrq(uartChTwoIrq),
        .tcIrq(terminalCount), .lineThree(irqThreeIn), .lineFour(irqFourIn));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Called after a falling edge; outputs are taken on the second falling edge after the start.
    task automatic access(input logic [15:0] a, input logic wr, st, mem, input logic [7:0] d);
        address = a;
        memNotIo = mem;
        setupN = !st;
        dataIn = d;
        ioWriteN = !wr;
        ioReadN = wr;
        cmdN = 1'h0;
        repeat (2) @(negedge clock);
        sel = {3'h0, cardSelect, channelOneSelectN, channelTwoSelectN, uartChipSelectN, uartChannelPick};
        rs = uartRegSelect;
        rd = dataOut;
        cmdN = 1'h1;
        ioWriteN = 1'h1;
        ioReadN = 1'h1;
        @(negedge clock);
    endtask : access

    function automatic logic [2:0] fld(input logic [15:0] a);
        return {~&{a[7], a[6], a[4]}, a[8], a[3]};
    endfunction : fld

    task automatic place(input logic [15:0] p1, p2);
        lo = {1'h0, fld(p1), fld(p2), 1'h1};
        hi = {2'h0, p1[14:12], p2[14:12]};
        access({13'h0000, CFG_LOW_INDEX}, 1'h1, 1'h1, 1'h0, lo);
        access({13'h0000, CFG_HIGH_INDEX}, 1'h1, 1'h1, 1'h0, hi);
        access({13'h0000, CFG_LOW_INDEX}, 1'h0, 1'h1, 1'h0, 8'h00);
        chk("cfgLowRead", lo, rd);
        access({13'h0000, CFG_HIGH_INDEX}, 1'h0, 1'h1, 1'h0, 8'h00);
        chk("cfgHighRead", hi, rd);
    endtask : place

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    // Tests take about 340 cycles; this allows 2000.
    initial begin
        #40000;
        fail_count++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {fail_count, checks} = '0;
        {rst_b, channelReset, memNotIo, address, dataIn, irqWant} = '0;
        {cmdN, ioReadN, ioWriteN, setupN} = 4'hF;
        repeat (5) @(negedge clock);
        rst_b = 1'h1;
        @(negedge clock);
        chk("cfgLow", CFG_RESET, portSelectConfigLow);
        chk("dmaEnable", DMA_ENABLE_RESET, dmaRequestEnable);
        chk("irqIdle", 8'h03, {6'h00, irqThreeOeN, irqFourOeN});
        access(PORTS[0], 1'h0, 1'h0, 1'h0, 8'h00);
        chk("selDisabled", 8'h0F, sel);
        $display("test reset done");
        for (int p = 0; p < 8; p++) begin
            c1 = PORTS[(p + 1) % 8];
            c2 = PORTS[p];
            place(c1, c2);
            access(c1 | 16'(p), 1'h0, 1'h0, 1'h0, 8'h00);
            chk("selOne", 8'h15, sel);
            chk("regSelect", 8'(p), {5'h00, rs});
            access(c2 | 16'(p), 1'h0, 1'h0, 1'h0, 8'h00);
            chk("selTwo", 8'h18, sel);
            foreach (FLIPS[i]) begin
                access(c1 ^ FLIPS[i], 1'h0, 1'h0, 1'h0, 8'h00);
                chk("selFlip", (c1 ^ FLIPS[i]) == c2 ? 8'h18 : 8'h0F, sel);
            end
            access(c1, 1'h0, 1'h0, 1'h1, 8'h00);
            chk("selMemory", 8'h0F, sel);
        end
        $display("test ports done");
        access(FIXED_REG_ADDR, 1'h1, 1'h0, 1'h0, 8'hA5);
        chk("dmaEnable", 8'hA5, dmaRequestEnable);
        irqWant = 3'h5;
        access(FIXED_REG_ADDR, 1'h0, 1'h0, 1'h0, 8'h00);
        chk("status", 8'h05, rd);
        chk("selFixed", 8'h1F, sel);
        $display("test fixed done");
        for (int w = 0; w < 8; w++) begin
            irqWant = 3'(w);
            repeat (2) @(negedge clock);
            rd = {6'h00, !(irqWant[2] | irqWant[1]), !irqWant[0]};
            chk("irqRoute", rd, {6'h00, irqThreeOeN, irqFourOeN});
            chk("irqWire", rd, {6'h00, irqThreeIn, irqFourIn});
        end
        irqWant = 3'h1;
        place(c2, c1);
        chk("irqSwap", 8'h01, {6'h00, irqThreeOeN, irqFourOeN});
        $display("test irq done");
        irqWant = 3'h7;
        channelReset = 1'h1;
        @(negedge clock);
        channelReset = 1'h0;
        @(negedge clock);
        chk("cfgAfterReset", CFG_RESET, portSelectConfigLow);
        chk("irqAfterReset", 8'h03, {6'h00, irqThreeOeN, irqFourOeN});
        access(c2, 1'h0, 1'h0, 1'h0, 8'h00);
        chk("selAfterReset", 8'h0F, sel);
        $display("test channel_reset done");
        complete_run();
    end
endmodule : dual_uart_port_decode_irq_bench
